// ==== src/cssc_pkg.sv ====
// Purpose: shared constants and types of the clock-synchronous serial channel
// Assumes: mclk at 125 MHz, 32-bit APB register access
// Notes:   one register per aligned word, 8-bit characters, lsb first
package cssc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register map
  localparam int unsigned APB_AW      = 8;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_TXBUF   = 8'h04;
  localparam logic [7:0]  OFF_RXBUF   = 8'h08;
  localparam logic [7:0]  OFF_STATUS  = 8'h0c;
  localparam logic [7:0]  OFF_INTSTAT = 8'h10;
  localparam logic [7:0]  OFF_INTMASK = 8'h14;

  // control fields
  localparam int unsigned CTRL_W      = 5;
  localparam int unsigned CTRL_TXEN   = 0;
  localparam int unsigned CTRL_RXEN   = 1;
  localparam int unsigned CTRL_INTCLK = 2;
  localparam int unsigned CTRL_POL    = 3;
  localparam int unsigned CTRL_HS     = 4;
  localparam logic [4:0]  CTRL_RST    = 5'h00;

  // status fields
  localparam int unsigned ST_TXEMPTY  = 0;
  localparam int unsigned ST_RXDONE   = 1;
  localparam int unsigned ST_OVERRUN  = 2;
  localparam int unsigned ST_BUSY     = 3;

  // interrupt events
  localparam int unsigned IRQ_W       = 2;
  localparam int unsigned IRQ_RX      = 0;
  localparam int unsigned IRQ_TX      = 1;
  localparam logic [1:0]  IRQ_RST     = 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned MCLK_NS         = 8;
  localparam int unsigned SHIFT_HALF_NS   = 80;
  localparam int unsigned SHIFT_HALF_CYC  = SHIFT_HALF_NS / MCLK_NS;
  localparam logic [3:0]  HALF_LAST       = 4'(SHIFT_HALF_CYC - 1);
  localparam logic [3:0]  LAST_BIT        = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READY = 3'b010,
    ST_SHIFT = 3'b100
  } cssc_state_type;

endpackage

// ==== src/cssc_link_if.sv ====
// Purpose: pins between the serial channel and its partner
// Assumes: shift clock pin is two-way and pulled high when undriven
// Notes:   level of the shared clock worked out from the enables here
interface cssc_link_if;
  logic dev_sclk_o;
  logic dev_sclk_oe;
  logic far_sclk_o;
  logic far_sclk_oe;
  logic shift_clock_pin;
  logic serial_out_pin;
  logic far_data;
  logic receive_ready_out_n;
  logic transmit_permit_in_n;

  assign shift_clock_pin = dev_sclk_oe ? dev_sclk_o : (far_sclk_oe ? far_sclk_o : 1'b1);

  modport dev (
    output dev_sclk_o,
    output dev_sclk_oe,
    output serial_out_pin,
    output receive_ready_out_n,
    input  shift_clock_pin,
    input  far_data,
    input  transmit_permit_in_n
  );

  modport far (
    output far_sclk_o,
    output far_sclk_oe,
    output far_data,
    output transmit_permit_in_n,
    input  shift_clock_pin,
    input  serial_out_pin,
    input  receive_ready_out_n
  );
endinterface

// ==== src/cssc_partner.sv ====
// Purpose: partner end, a plain clock-synchronous shifter
// Assumes: user side pulses start with tx_byte valid while busy is low
// Notes:   makes the shift clock when clk_master, else follows the device clock
module cssc_partner
  import cssc_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // user side
  input  wire logic       clk_master,
  input  wire logic       clk_pol,
  input  wire logic       use_permit,
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            busy,
  // link
  cssc_link_if.far        link
);

  ////////////////////////////////////////////////////////////////////////
  cssc_state_type st_r;
  cssc_state_type st_nxt;
  logic       sck_s1, sck_s2, sck_s3;
  logic       dat_s1, dat_s2;
  logic       rdy_s1, rdy_s2;
  logic [7:0] tx_sh_r;
  logic [7:0] rx_sh_r;
  logic [3:0] bit_cnt_r;
  logic [3:0] half_cnt_r;
  logic       sclk_r;
  logic       oe_r;
  logic       data_r;
  logic       permit_n_r;

  wire idle_lvl  = ~clk_pol;
  wire half_hit  = half_cnt_r == HALF_LAST;
  wire own_edge  = st_r == ST_SHIFT && oe_r && half_hit;
  wire own_drive = own_edge && sclk_r == idle_lvl;
  wire own_samp  = own_edge && sclk_r != idle_lvl;
  wire ext_rise  = sck_s2 & ~sck_s3;
  wire ext_fall  = ~sck_s2 & sck_s3;
  wire ext_drive = ~oe_r && (clk_pol ? ext_rise : ext_fall);
  wire ext_samp  = ~oe_r && (clk_pol ? ext_fall : ext_rise);
  // with use_permit set, device must show receive-ready before a clock is made
  wire go_own    = st_r == ST_READY && oe_r && (~use_permit || ~rdy_s2);
  wire drive     = (st_r == ST_SHIFT || (st_r == ST_READY && ~oe_r)) && (oe_r ? own_drive : ext_drive);
  wire samp      = st_r == ST_SHIFT && (oe_r ? own_samp : ext_samp);
  wire last_samp = samp && bit_cnt_r == LAST_BIT;

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:  if (start) st_nxt = ST_READY;
      ST_READY: if (go_own || drive) st_nxt = ST_SHIFT;
      ST_SHIFT: if (last_samp) st_nxt = ST_IDLE;
      default:  st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    sck_s1 <= link.shift_clock_pin;
    sck_s2 <= sck_s1;
    sck_s3 <= sck_s2;
    dat_s1 <= link.serial_out_pin;
    dat_s2 <= dat_s1;
    rdy_s1 <= link.receive_ready_out_n;
    rdy_s2 <= rdy_s1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_r       <= ST_IDLE;
      tx_sh_r    <= 8'h00;
      rx_sh_r    <= 8'h00;
      bit_cnt_r  <= 4'h0;
      half_cnt_r <= 4'h0;
      sclk_r     <= 1'b1;
      oe_r       <= 1'b0;
      data_r     <= 1'b1;
      permit_n_r <= 1'b1;
      rx_byte    <= 8'h00;
      rx_valid   <= 1'b0;
      busy       <= 1'b0;
    end
    else
    begin
      st_r       <= st_nxt;
      oe_r       <= (st_r == ST_IDLE) ? clk_master : oe_r;
      permit_n_r <= ~(st_r == ST_READY);
      busy       <= st_nxt != ST_IDLE;
      rx_valid   <= last_samp;
      if (start && st_r == ST_IDLE)
        tx_sh_r <= tx_byte;
      else if (drive)
        tx_sh_r <= {1'b1, tx_sh_r[7:1]};
      if (drive)
        data_r <= tx_sh_r[0];
      if (samp)
        rx_sh_r <= {dat_s2, rx_sh_r[7:1]};
      if (last_samp)
        rx_byte <= {dat_s2, rx_sh_r[7:1]};
      if (st_r != ST_SHIFT)
        bit_cnt_r <= 4'h0;
      else if (samp)
        bit_cnt_r <= bit_cnt_r + 4'h1;
      half_cnt_r <= (st_r == ST_SHIFT && oe_r && !half_hit) ? half_cnt_r + 4'h1 : 4'h0;
      // clock rests at the idle level of the chosen polarity
      if (own_edge)
        sclk_r <= ~sclk_r;
      else if (st_r != ST_SHIFT)
        sclk_r <= idle_lvl;
    end
  end

  assign link.far_sclk_o           = sclk_r;
  assign link.far_sclk_oe          = oe_r;
  assign link.far_data             = data_r;
  assign link.transmit_permit_in_n = permit_n_r;

endmodule

// ==== src/cssc_channel.sv ====
// Purpose: device end, clock-synchronous serial channel with APB registers
// Assumes: partner follows the set-up order for external clocking
// Notes:   reception rides on transmission; one character in flight
module cssc_channel
  import cssc_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // apb slave
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // interrupt
  output logic                   irq,
  // link
  cssc_link_if.dev               link
);

  ////////////////////////////////////////////////////////////////////////
  // state
  cssc_state_type     st_r;
  cssc_state_type     st_nxt;
  logic [CTRL_W-1:0]  ctrl_r;
  logic [7:0]         tx_buf_r;
  logic               tx_empty_r;
  logic [7:0]         rx_buf_r;
  logic               rx_done_r;
  logic               ovr_r;
  logic [IRQ_W-1:0]   ist_r;
  logic [IRQ_W-1:0]   imask_r;
  logic [7:0]         tx_sh_r;
  logic [7:0]         rx_sh_r;
  logic [3:0]         bit_cnt_r;
  logic [3:0]         half_cnt_r;
  logic               sclk_r;
  logic               txd_r;
  logic               rx_busy_r;
  logic               rts_n_r;
  logic               sck_s1;
  logic               sck_s2;
  logic               sck_s3;
  logic               rxd_s1;
  logic               rxd_s2;
  logic               cts_s1;
  logic               cts_s2;
  logic [31:0]        rdata;

  ////////////////////////////////////////////////////////////////////////
  // control decode
  wire tx_en    = ctrl_r[CTRL_TXEN];
  wire rx_en    = ctrl_r[CTRL_RXEN];
  wire int_clk  = ctrl_r[CTRL_INTCLK];
  wire pol      = ctrl_r[CTRL_POL];
  wire hs       = ctrl_r[CTRL_HS];
  wire idle_lvl = ~pol;

  // apb decode
  wire sel_ctrl  = paddr == OFF_CTRL;
  wire sel_txbuf = paddr == OFF_TXBUF;
  wire sel_rxbuf = paddr == OFF_RXBUF;
  wire sel_stat  = paddr == OFF_STATUS;
  wire sel_ist   = paddr == OFF_INTSTAT;
  wire sel_imask = paddr == OFF_INTMASK;
  wire hit       = sel_ctrl | sel_txbuf | sel_rxbuf | sel_stat | sel_ist | sel_imask;
  wire setup     = psel & ~penable;
  wire acc       = psel & penable & pready;
  wire wr        = acc & pwrite;
  wire rd        = acc & ~pwrite;

  ////////////////////////////////////////////////////////////////////////
  // shift edges, internal divider or synchronised pin
  wire half_hit  = half_cnt_r == HALF_LAST;
  wire int_edge  = st_r == ST_SHIFT && int_clk && half_hit;
  wire int_drive = int_edge && sclk_r == idle_lvl;
  wire int_samp  = int_edge && sclk_r != idle_lvl;
  wire ext_rise  = sck_s2 & ~sck_s3;
  wire ext_fall  = ~sck_s2 & sck_s3;
  wire ext_drive = ~int_clk && (pol ? ext_rise : ext_fall);
  wire ext_samp  = ~int_clk && (pol ? ext_fall : ext_rise);

  // transmitter loads only when enabled and the buffer holds data
  wire load      = st_r == ST_IDLE && tx_en && ~tx_empty_r;
  wire permit_ok = ~hs | ~cts_s2;
  wire start_int = st_r == ST_READY && int_clk && tx_en && permit_ok;
  // external edges count only once armed by the transmitter
  wire drive     = (st_r == ST_SHIFT || (st_r == ST_READY && ~int_clk)) && (int_clk ? int_drive : ext_drive);
  wire samp      = st_r == ST_SHIFT && (int_clk ? int_samp : ext_samp);
  wire last_samp = samp && bit_cnt_r == LAST_BIT;
  wire [7:0] rx_word = {rxd_s2, rx_sh_r[7:1]};
  wire rx_store  = last_samp && rx_en;
  wire rx_start  = drive && bit_cnt_r == 4'h0 && ~rx_busy_r && rx_en;

  // interrupt events, overrun raises none
  wire [IRQ_W-1:0] ev_set = {load, rx_store & ~rx_done_r};
  wire [IRQ_W-1:0] ev_clr = (wr && sel_ist) ? pwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] ist_nxt = (ist_r & ~ev_clr) | ev_set;

  ////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:  if (load) st_nxt = ST_READY;
      ST_READY:
        if (!tx_en)
          st_nxt = ST_IDLE;
        else if (start_int || drive)
          st_nxt = ST_SHIFT;
      ST_SHIFT: if (last_samp) st_nxt = ST_IDLE;
      default:  st_nxt = ST_IDLE;
    endcase
  end

  always_comb
  begin
    rdata = 32'h0000_0000;
    if (sel_ctrl)
      rdata[CTRL_W-1:0] = ctrl_r;
    else if (sel_txbuf)
      rdata[7:0] = tx_buf_r;
    else if (sel_rxbuf)
      rdata[7:0] = rx_buf_r;
    else if (sel_stat)
      rdata[3:0] = {st_r != ST_IDLE, ovr_r, rx_done_r, tx_empty_r};
    else if (sel_ist)
      rdata[IRQ_W-1:0] = ist_r;
    else if (sel_imask)
      rdata[IRQ_W-1:0] = imask_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronisers
  always_ff @(posedge mclk)
  begin
    sck_s1 <= link.shift_clock_pin;
    sck_s2 <= sck_s1;
    sck_s3 <= sck_s2;
    rxd_s1 <= link.far_data;
    rxd_s2 <= rxd_s1;
    cts_s1 <= link.transmit_permit_in_n;
    cts_s2 <= cts_s1;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and bus
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ctrl_r     <= CTRL_RST;
      tx_buf_r   <= 8'h00;
      tx_empty_r <= 1'b1;
      rx_buf_r   <= 8'h00;
      rx_done_r  <= 1'b0;
      ovr_r      <= 1'b0;
      ist_r      <= IRQ_RST;
      imask_r    <= IRQ_RST;
      irq        <= 1'b0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= setup ? rdata : 32'h0000_0000;
      if (wr && sel_ctrl)
        ctrl_r <= pwdata[CTRL_W-1:0];
      if (wr && sel_imask)
        imask_r <= pwdata[IRQ_W-1:0];
      // dummy bytes land in the low byte
      if (wr && sel_txbuf)
        tx_buf_r <= pwdata[7:0];
      if (wr && sel_txbuf)
        tx_empty_r <= 1'b0;
      else if (load)
        tx_empty_r <= 1'b1;
      if (rx_store)
        rx_buf_r <= rx_word;
      if (rx_store)
        rx_done_r <= 1'b1;
      else if (rd && sel_rxbuf)
        rx_done_r <= 1'b0;
      if (rx_store && rx_done_r)
        ovr_r <= 1'b1;
      else if (wr && sel_stat && pwdata[ST_OVERRUN])
        ovr_r <= 1'b0;
      ist_r <= ist_nxt;
      irq   <= |(ist_nxt & imask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shifter
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_r       <= ST_IDLE;
      tx_sh_r    <= 8'h00;
      rx_sh_r    <= 8'h00;
      bit_cnt_r  <= 4'h0;
      half_cnt_r <= 4'h0;
      sclk_r     <= 1'b1;
      txd_r      <= 1'b1;
      rx_busy_r  <= 1'b0;
      rts_n_r    <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      if (load)
        tx_sh_r <= tx_buf_r;
      else if (drive)
        tx_sh_r <= {1'b1, tx_sh_r[7:1]};
      // dummy data goes out while receiving
      if (drive)
        txd_r <= tx_sh_r[0];
      if (samp)
        rx_sh_r <= rx_word;
      if (st_r != ST_SHIFT)
        bit_cnt_r <= 4'h0;
      else if (samp)
        bit_cnt_r <= bit_cnt_r + 4'h1;
      half_cnt_r <= (st_r == ST_SHIFT && int_clk && !half_hit) ? half_cnt_r + 4'h1 : 4'h0;
      if (int_edge)
        sclk_r <= ~sclk_r;
      else if (st_r != ST_SHIFT)
        sclk_r <= idle_lvl;
      if (last_samp)
        rx_busy_r <= 1'b0;
      else if (rx_start)
        rx_busy_r <= 1'b1;
      // ready only with external clock and handshake on
      rts_n_r <= ~(hs & ~int_clk & rx_en & ~rx_busy_r);
    end
  end

  assign link.dev_sclk_o          = sclk_r;
  assign link.dev_sclk_oe         = ctrl_r[CTRL_INTCLK];
  assign link.serial_out_pin      = txd_r;
  assign link.receive_ready_out_n = rts_n_r;

endmodule

// ==== dv/cssc_link_assertions.sv ====
// Purpose: link-side checks of the serial channel pair
// Assumes: internal shift clock half period of 10 mclk
// Notes:   sees the interface signals only
module cssc_assertions
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // link
  input wire logic dev_sclk_o,
  input wire logic dev_sclk_oe,
  input wire logic far_sclk_o,
  input wire logic far_sclk_oe,
  input wire logic shift_clock_pin,
  input wire logic serial_out_pin,
  input wire logic receive_ready_out_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       pin_q;
  logic       clk_q;
  logic [3:0] age_r;
  logic [3:0] tog_r;

  default clocking chk_cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////
  // cycles since the pin last moved, saturating
  always_ff @(posedge mclk)
  begin
    pin_q <= shift_clock_pin;
    if (!rstn || shift_clock_pin != pin_q)
      age_r <= 4'h0;
    else if (age_r != 4'hf)
      age_r <= age_r + 4'h1;
  end

  // device clock toggles within one character
  always_ff @(posedge mclk)
  begin
    clk_q <= dev_sclk_o;
    // a toggle after a long rest is the first of a character
    if (!rstn || !dev_sclk_oe)
      tog_r <= 4'h0;
    else if (dev_sclk_o != clk_q)
      tog_r <= tog_r + 4'h1;
    else if (age_r > 4'hc)
      tog_r <= 4'h0;
  end

  sequence clk_edge_s;
    dev_sclk_oe && $changed(dev_sclk_o);
  endsequence

  ////////////////////////////////////////////////////////////////////////
  reset_idle_a: assert property ($rose(rstn) |-> receive_ready_out_n && serial_out_pin && !dev_sclk_oe)
    else $error("link not idle after reset");
  internal_ready_a: assert property (dev_sclk_oe && $past(dev_sclk_oe) |-> receive_ready_out_n)
    else $error("ready low under internal clock");
  half_period_a: assert property (clk_edge_s |=> $stable(dev_sclk_o) [*8])
    else $error("shift clock half period too short");
  pair_period_a: assert property (clk_edge_s ##0 !tog_r[0] |-> ##10 $changed(dev_sclk_o))
    else $error("shift clock pulse not 10 cycles");
  data_hold_a: assert property (clk_edge_s ##0 (tog_r[0] && tog_r != 4'hf) |-> $stable(serial_out_pin))
    else $error("serial data moved on sample edge");
  ready_busy_a: assert property (!dev_sclk_oe && far_sclk_oe && $changed(far_sclk_o)
                                 |-> ##[1:5] receive_ready_out_n)
    else $error("ready low during reception");
  ready_rise_a: assert property (!dev_sclk_oe && $rose(receive_ready_out_n) |-> age_r <= 4'h5)
    else $error("ready rose without clock edge");
  ready_fall_a: assert property ($fell(receive_ready_out_n) |-> !dev_sclk_oe && !$past(dev_sclk_oe))
    else $error("ready fell under internal clock");
endmodule

// ==== dv/clock_sync_serial_channel_tb_top.sv ====
// Purpose: testbench of the serial channel facing its partner end
// Assumes: zero-wait APB slave, partner driven on its user side
// Notes:   register and link traffic compared with expected values
module clock_sync_serial_channel_tb_top
  import cssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // tx, rx, internal clock, handshake
  localparam logic [31:0] EN_INT = 32'h17;

  logic              mclk;
  logic              rstn;
  logic [APB_AW-1:0] paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              clk_master;
  logic              clk_pol;
  logic              use_permit;
  logic              start;
  logic [7:0]        tx_byte;
  logic [7:0]        rx_byte;
  logic              rx_valid;
  logic              busy;
  int                err_total;
  int                checked;
  logic              seen_hi;
  logic              last_err;
  logic [31:0]       rdata;

  cssc_link_if link_i ();

  cssc_channel cssc_channel_i (
    .mclk    (mclk),
    .rstn    (rstn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq),
    .link    (link_i)
  );

  cssc_partner cssc_partner_i (
    .mclk       (mclk),
    .rstn       (rstn),
    .clk_master (clk_master),
    .clk_pol    (clk_pol),
    .use_permit (use_permit),
    .start      (start),
    .tx_byte    (tx_byte),
    .rx_byte    (rx_byte),
    .rx_valid   (rx_valid),
    .busy       (busy),
    .link       (link_i)
  );

  cssc_assertions cssc_assertions_i (
    .mclk                (mclk),
    .rstn                (rstn),
    .dev_sclk_o          (link_i.dev_sclk_o),
    .dev_sclk_oe         (link_i.dev_sclk_oe),
    .far_sclk_o          (link_i.far_sclk_o),
    .far_sclk_oe         (link_i.far_sclk_oe),
    .shift_clock_pin     (link_i.shift_clock_pin),
    .serial_out_pin      (link_i.serial_out_pin),
    .receive_ready_out_n (link_i.receive_ready_out_n)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic timeout();
    err_total++;
    give_verdict();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; pready !== 1'b1; n++)
    begin
      if (n > 20)
        timeout();
      @(posedge mclk);
    end
    rdata    = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdata, exp);
  endtask

  // status polled until all bits of m are set
  task automatic poll(input logic [31:0] m);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end
    while ((rdata & m) !== m && n < 100);
    check(rdata & m, m);
  endtask

  task automatic wait_rx();
    int n;
    for (n = 0; rx_valid !== 1'b1; n++)
    begin
      if (n > 2000)
        timeout();
      @(posedge mclk);
      if (link_i.receive_ready_out_n === 1'b1)
        seen_hi = 1'b1;
    end
  endtask

  // device sends dv while partner sends fb
  task automatic xfer(input logic ext, input logic [7:0] dv, input logic [7:0] fb);
    if (ext)
    begin
      wr(OFF_TXBUF, {24'h0, dv});
      rd(OFF_STATUS, 32'h9);
    end
    start   <= 1'b1;
    tx_byte <= fb;
    @(posedge mclk);
    start <= 1'b0;
    if (!ext)
      wr(OFF_TXBUF, {24'h0, dv});
    else
      @(posedge mclk);
    check({31'h0, busy}, 32'h1);
    wait_rx();
    check({31'h0, busy}, 32'h0);
    check({24'h0, rx_byte}, {24'h0, dv});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever
      #4 mclk = ~mclk;
  end

  initial
  begin
    rstn       = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = '0;
    pwdata     = 32'h0;
    clk_master = 1'b0;
    clk_pol    = 1'b0;
    use_permit = 1'b0;
    start      = 1'b0;
    tx_byte    = 8'h00;
    err_total  = 0;
    checked    = 0;
    seen_hi    = 1'b0;
    repeat (4)
      @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd(OFF_CTRL, 32'h0);
    rd(OFF_STATUS, 32'h1);
    rd(OFF_INTSTAT, 32'h0);
    rd(8'h18, 32'h0);
    check({31'h0, last_err}, 32'h1);
    check({31'h0, link_i.receive_ready_out_n}, 32'h1);
    wr(OFF_INTMASK, 32'h1);
    for (int p = 0; p < 2; p++)
    begin
      clk_pol <= p[0];
      wr(OFF_CTRL, 32'(p) << CTRL_POL);
      wr(OFF_CTRL, (32'(p) << CTRL_POL) | EN_INT);
      xfer(1'b0, 8'h3c ^ 8'(p), 8'ha5 ^ 8'(p));
      check({31'h0, link_i.receive_ready_out_n}, 32'h1);
      poll(32'h2);
      check({31'h0, irq}, 32'h1);
      rd(OFF_INTSTAT, 32'h3);
      wr(OFF_INTSTAT, 32'h3);
      xfer(1'b0, 8'h5a, 8'hc3 ^ 8'(p));
      poll(32'h4);
      rd(OFF_INTSTAT, 32'h2);
      check({31'h0, irq}, 32'h0);
      rd(OFF_RXBUF, {24'h0, 8'hc3 ^ 8'(p)});
      rd(OFF_STATUS, 32'h5);
      wr(OFF_STATUS, 32'h4);
      wr(OFF_INTSTAT, 32'h3);
      rd(OFF_STATUS, 32'h1);
    end
    wr(OFF_CTRL, 32'h0);
    clk_pol    <= 1'b0;
    clk_master <= 1'b1;
    use_permit <= 1'b1;
    wr(OFF_CTRL, 32'h12);
    rd(OFF_STATUS, 32'h1);
    check({31'h0, link_i.receive_ready_out_n}, 32'h0);
    wr(OFF_CTRL, 32'h13);
    seen_hi = 1'b0;
    xfer(1'b1, 8'h69, 8'h96);
    check({31'h0, seen_hi}, 32'h1);
    poll(32'h2);
    check({31'h0, link_i.receive_ready_out_n}, 32'h0);
    rd(OFF_RXBUF, 32'h96);
    rd(OFF_STATUS, 32'h1);
    give_verdict();
  end
endmodule
